// ===== dv/test_acc_flags.sv
/*
 Self-checking bench for acc_flags: an integer model of the accumulator and
 status flags is compared with the ports after every operation.
 Assumes the package types and the two-edge ACC and FLAGS latency of the design.
*/
`timescale 1ns/1ps
module test_acc_flags;
	import acc_flags_pkg::*;

	logic       clk;
	logic       reset;
	alu_req_t   alu_req;
	mem_req_t   mem_req;
	logic       save, restore, int_entry, opt_high, opt_mid, lv_high, lv_mid;
	logic [1:0] cause;
	logic [7:0] acc, flags, mem_rdata, alu_result;
	logic       result_valid;
	int         bad_count, total_checks, seed, ma, mc, mdc, mz, i, sa, sc, sdc, sz;
	alu_op_t    ops[10] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_OR, OP_XOR,
		OP_LOAD, OP_BRANCH};
	logic [1:0] causes[3] = '{CAUSE_WDOG, CAUSE_LVD, CAUSE_PIN};

	acc_flags dut_u (.CLK(clk), .RESET(reset), .ALU_REQ(alu_req), .MEM_REQ(mem_req),
		.SAVE(save), .RESTORE(restore), .INT_ENTRY(int_entry), .RESET_CAUSE(cause),
		.OPT_HIGH(opt_high), .OPT_MID(opt_mid), .LV_HIGH_IN(lv_high), .LV_MID_IN(lv_mid),
		.ACC(acc), .FLAGS(flags), .MEM_RDATA(mem_rdata), .ALU_RESULT(alu_result),
		.RESULT_VALID(result_valid));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
			bad_count++;
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// requests are one-cycle pulses; ACC and FLAGS show the result two edges later
	task automatic settle();
		@(posedge clk);
		alu_req.valid <= 1'b0;
		mem_req.valid <= 1'b0;
		save          <= 1'b0;
		restore       <= 1'b0;
		int_entry     <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic check_state(input string what);
		chk(acc, ma[7:0], what);
		chk({4'h0, flags[3:0]}, {5'h00, mc[0], mdc[0], mz[0]}, what);
	endtask

	task automatic do_reset(input logic [1:0] c);
		@(posedge clk);
		reset <= 1'b1;
		cause <= c;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		{ma, mc, mdc, mz} = '0;
		chk(flags, {c, 6'h00}, "reset flags");
		chk(acc, ACC_RESET, "reset acc");
	endtask

	task automatic run_op(input alu_op_t o, input logic [7:0] b);
		int cin;
		int s;
		int bi;
		bi = b;
		cin = (o == OP_ADC || o == OP_SBC) ? mc : 0;
		@(posedge clk);
		alu_req <= {1'b1, o, b, 1'b0};
		case (o)
			OP_ADD, OP_ADC:
			begin
				s = ma + b + cin;
				mdc = ((ma & 15) + (b & 15) + cin) > 15;
				mc = s > 255;
				ma = s & 255;
				mz = ma == 0;
			end
			// carry set means no borrow; signed ints keep the borrow test honest
			OP_SUB, OP_SBC:
			begin
				cin = (o == OP_SUB) ? 1 : cin;
				mdc = ((ma & 15) - (bi & 15) - 1 + cin) >= 0;
				s = ma - bi - 1 + cin;
				mc = s >= 0;
				ma = s & 255;
				mz = ma == 0;
			end
			OP_LOAD:
			begin
				ma = bi;
				mz = ma == 0;
			end
			OP_BRANCH: mz = bi == 0;
			OP_CMP:
			begin
				mc = ma >= b;
				mz = ma == b;
			end
			default:
			begin
				ma = (o == OP_AND) ? (ma & b) : (o == OP_OR) ? (ma | b) : (ma ^ b);
				mz = ma == 0;
			end
		endcase
		settle();
		check_state("alu op");
	endtask

	task automatic mem(input logic [7:0] a, input logic bo, input logic bv,
		input logic [2:0] s, input logic [7:0] d);
		@(posedge clk);
		mem_req <= {1'b1, a, 1'b1, bo, bv, s, d};
		settle();
	endtask

	// rotate through carry into memory: accumulator must stay, C and Z follow
	task automatic rotate(input alu_op_t o, input logic [7:0] b);
		logic [7:0] r;
		r = (o == OP_RRC) ? {mc[0], b[7:1]} : {b[6:0], mc[0]};
		mc = (o == OP_RRC) ? b[0] : b[7];
		mz = r == 8'h00;
		@(posedge clk);
		alu_req <= {1'b1, o, b, 1'b1};
		@(posedge clk);
		alu_req.valid <= 1'b0;
		#1;
		chk(alu_result, r, "rotate result");
		chk({7'h00, result_valid}, 8'h01, "result pulse");
		settle();
		check_state("rotate");
	endtask

	task automatic wait_bit(input int idx, input logic v);
		for (int k = 0; k < 12 && flags[idx] !== v; k++)
			@(posedge clk);
		#1;
		chk({7'h00, flags[idx]}, {7'h00, v}, "detector flag");
	endtask

	initial
	begin
		{reset, save, restore, int_entry} = 4'h8;
		{opt_high, opt_mid, lv_high, lv_mid} = 4'h0;
		alu_req = '0;
		mem_req = '0;
		cause = CAUSE_PIN;
		seed = 14861;
		bad_count = 0;
		total_checks = 0;
		foreach (causes[k])
			do_reset(causes[k]);
		$display("test reset cause done");
		for (i = 0; i < 60; i++)
			run_op(ops[$unsigned($random(seed)) % 10], 8'($random(seed)));
		$display("test alu done");
		@(posedge clk);
		int_entry <= 1'b1;
		settle();
		check_state("interrupt entry");
		mem(8'h85, 1'b0, 1'b0, 3'h0, 8'hFF);
		check_state("unmapped write");
		$display("test interrupt and unmapped done");
		mem(FLAGS_ADDR, 1'b0, 1'b0, 3'h0, 8'hF7);
		chk(flags, 8'hC7, "flag write");
		@(posedge clk);
		mem_req <= {1'b1, FLAGS_ADDR, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00};
		@(posedge clk);
		mem_req.valid <= 1'b0;
		#1;
		chk(mem_rdata, 8'hC7, "flag read");
		mem(FLAGS_ADDR, 1'b0, 1'b0, 3'h0, 8'h00);
		mem(FLAGS_ADDR, 1'b1, 1'b1, 3'(BIT_CARRY), 8'h00);
		mem(FLAGS_ADDR, 1'b1, 1'b1, 3'(BIT_LV_HIGH), 8'h00);
		chk(flags, 8'h04, "bit set");
		$display("test flag register done");
		// flag writes left C set, DC and Z clear; the accumulator was not touched
		{mc, mdc, mz} = {32'd1, 32'd0, 32'd0};
		run_op(OP_ADD, 8'h0F);
		@(posedge clk);
		save <= 1'b1;
		{sa, sc, sdc, sz} = {ma, mc, mdc, mz};
		settle();
		rotate(OP_RRC, 8'h01);
		rotate(OP_RLC, 8'h7F);
		@(posedge clk);
		restore <= 1'b1;
		{ma, mc, mdc, mz} = {sa, sc, sdc, sz};
		settle();
		check_state("restore");
		$display("test save and restore done");
		do_reset(CAUSE_LVD);
		check_state("reset clears state");
		$display("test mid-run reset done");
		@(posedge clk);
		opt_high <= 1'b1;
		lv_high <= 1'b1;
		wait_bit(BIT_LV_HIGH, 1'b1);
		@(posedge clk);
		lv_high <= 1'b0;
		wait_bit(BIT_LV_HIGH, 1'b0);
		@(posedge clk);
		opt_mid <= 1'b1;
		lv_mid <= 1'b1;
		wait_bit(BIT_LV_MID, 1'b1);
		@(posedge clk);
		opt_mid <= 1'b0;
		wait_bit(BIT_LV_MID, 1'b0);
		$display("test detector flags done");
		summarize();
	end

	// a hang ends the run through the same report
	initial
	begin
		repeat (100000) @(posedge clk);
		$display("[FAIL] %0t run did not finish in time", $time);
		bad_count++;
		summarize();
	end
endmodule

// ===== pkg/acc_flags_pkg.sv
/*
 Shared types and constants for the accumulator and status flag block.
 Assumes a core that presents one decoded operation per clock.
*/
package acc_flags_pkg;

	localparam logic [7:0] FLAGS_ADDR   = 8'h86;
	localparam int         BIT_CAUSE_HI = 7;
	localparam int         BIT_CAUSE_LO = 6;
	localparam int         BIT_LV_HIGH  = 5;
	localparam int         BIT_LV_MID   = 4;
	localparam int         BIT_CARRY    = 2;
	localparam int         BIT_HALF     = 1;
	localparam int         BIT_ZERO     = 0;
	localparam logic [7:0] FLAGS_WMASK  = 8'hC7;
	localparam logic [7:0] ACC_RESET    = 8'h00;
	localparam logic [1:0] CAUSE_WDOG   = 2'h0;
	localparam logic [1:0] CAUSE_LVD    = 2'h2;
	localparam logic [1:0] CAUSE_PIN    = 2'h3;
	localparam logic [2:0] ALU_RESET    = 3'h0;

	typedef enum logic [3:0]
	{
		OP_NONE,
		OP_ADD,
		OP_ADC,
		OP_SUB,
		OP_SBC,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_RRC,
		OP_RLC,
		OP_CMP,
		OP_LOAD,
		OP_BRANCH
	} alu_op_t;

	typedef struct packed
	{
		logic       valid;
		alu_op_t    op;
		logic [7:0] operand;
		logic       to_mem;
	} alu_req_t;

	typedef struct packed
	{
		logic       valid;
		logic [7:0] addr;
		logic       write;
		logic       bit_op;
		logic       bit_val;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} mem_req_t;

	typedef struct packed
	{
		logic [7:0] result;
		logic       carry;
		logic       half;
		logic       zero;
		logic       upd_carry;
		logic       upd_half;
	} alu_res_t;

endpackage

// ===== rtl/acc_alu.sv
/*
 Combinational ALU for the accumulator: result and carry, half carry, zero.
 Assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
module acc_alu
	import acc_flags_pkg::*;
(
	input  wire acc_flags_pkg::alu_op_t  op,        // operation
	input  wire logic [7:0]              acc,       // accumulator
	input  wire logic [7:0]              operand,   // memory or immediate
	input  wire logic                    carry_in,  // current carry flag
	output acc_flags_pkg::alu_res_t      res        // result and flag updates
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic       cin;

	always_comb
	begin
		res = '0;
		sum = '0;
		nib = '0;
		cin = (op == OP_ADC || op == OP_SBC) ? carry_in : (op == OP_SUB || op == OP_CMP);
		case (op)
			OP_ADD, OP_ADC:
			begin
				sum = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
				nib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
				res.upd_carry = 1'b1;
				res.upd_half  = 1'b1;
			end
			// subtraction as add of complement: carry set means no borrow
			OP_SUB, OP_SBC, OP_CMP:
			begin
				sum = {1'b0, acc} + {1'b0, ~operand} + {8'h00, cin};
				nib = {1'b0, acc[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, cin};
				res.upd_carry = 1'b1;
				res.upd_half  = (op != OP_CMP);
			end
			OP_AND:    sum = {1'b0, acc & operand};
			OP_OR:     sum = {1'b0, acc | operand};
			OP_XOR:    sum = {1'b0, acc ^ operand};
			OP_RRC:
			begin
				sum = {operand[0], carry_in, operand[7:1]};
				res.upd_carry = 1'b1;
			end
			OP_RLC:
			begin
				sum = {operand, carry_in};
				res.upd_carry = 1'b1;
			end
			OP_LOAD, OP_BRANCH: sum = {1'b0, operand};
			default:   sum = {1'b0, acc};
		endcase
		res.result = sum[7:0];
		res.carry  = sum[8];
		res.half   = nib[4];
		res.zero   = (sum[7:0] == 8'h00);
	end
endmodule

// ===== rtl/acc_flags.sv
/*
 Accumulator, status flag register, save/restore buffers and flag register port.
 Assumes the core decodes instructions and presents one request per clock;
 voltage detector levels and reset cause come from asynchronous analog logic.
*/
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) eight-bit accumulator; operations update zero, carries
// (RULE_02) accumulator has no data memory address
// (RULE_03) interrupt entry leaves accumulator and flags alone
// (RULE_04) save copies both to buffers; restore reloads
// (RULE_05) bits seven, six give last reset cause
// (RULE_06) bit five: supply at/below high threshold
// (RULE_07) bit four: supply at/below mid threshold
// (RULE_08) bit two is the carry flag
// (RULE_09) bit one is the nibble half carry
// (RULE_10) bit zero set when result is zero
// (RULE_11) bit set/clear only on read-write registers
// (RULE_12) software writes fixed bits with shown values
// (RULE_13) writes skip detector flags; bit three reads zero
module acc_flags
	import acc_flags_pkg::*;
(
	input  wire logic                    CLK,          // 200 MHz core clock
	input  wire logic                    RESET,        // synchronous, active high
	input  wire acc_flags_pkg::alu_req_t ALU_REQ,      // accumulator operation
	input  wire acc_flags_pkg::mem_req_t MEM_REQ,      // data memory access to flags
	input  wire logic                    SAVE,         // save instruction
	input  wire logic                    RESTORE,      // restore instruction
	input  wire logic                    INT_ENTRY,    // interrupt vector taken
	input  wire logic [1:0]              RESET_CAUSE,  // cause of the reset in force
	input  wire logic                    OPT_HIGH,     // detector_option_high
	input  wire logic                    OPT_MID,      // detector_option_mid
	input  wire logic                    LV_HIGH_IN,   // comparator, supply <= 3.6 V
	input  wire logic                    LV_MID_IN,    // comparator, supply <= 2.4 V
	output logic [7:0]                   ACC,          // work_accumulator
	output logic [7:0]                   FLAGS,        // program_status_flags
	output logic [7:0]                   MEM_RDATA,    // flag register read data
	output logic [7:0]                   ALU_RESULT,   // result headed for memory
	output logic                         RESULT_VALID  // ALU_RESULT valid pulse
);
	logic [7:0]  work_accumulator;
	logic [1:0]  reset_cause;
	logic        supply_low_high_thresh_flag;
	logic        supply_low_mid_thresh_flag;
	logic        carry;
	logic        nibble_half_bit;
	logic        zero;
	logic [7:0]  save_acc;
	logic [7:0]  save_flags;
	logic [2:0]  sync_high;
	logic [2:0]  sync_mid;
	logic        caught;
	alu_res_t    alu;
	logic        flags_hit;
	logic [7:0]  next_flags;
	logic [7:0]  status_now;

	function automatic logic [7:0] pack_flags(input logic [1:0] rc, input logic hi,
		input logic mid, input logic c, input logic dc, input logic z);
		pack_flags = {rc, hi, mid, 1'b0, c, dc, z};
	endfunction

	// live view of the register; the FLAGS port lags it by one clock, so save,
	// read and bit ops take this one to avoid acting on a stale copy
	assign status_now = pack_flags(reset_cause, supply_low_high_thresh_flag,
		supply_low_mid_thresh_flag, carry, nibble_half_bit, zero); // RULE_13

	acc_alu u_alu
	(
		.op       (ALU_REQ.op),
		.acc      (work_accumulator),
		.operand  (ALU_REQ.operand),
		.carry_in (carry),
		.res      (alu)
	);

	// the accumulator is never decoded as a memory address
	assign flags_hit = MEM_REQ.valid && MEM_REQ.addr == FLAGS_ADDR; // RULE_02

	// bit ops are read-modify-write on the flag register, which is read-write
	always_comb
	begin
		next_flags = status_now;
		if (MEM_REQ.bit_op)
			next_flags[MEM_REQ.bit_sel] = MEM_REQ.bit_val; // RULE_11
		else
			next_flags = MEM_REQ.wdata;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			work_accumulator <= ACC_RESET;
		else if (RESTORE)
			work_accumulator <= save_acc; // RULE_04
		else if (ALU_REQ.valid && !ALU_REQ.to_mem && ALU_REQ.op != OP_CMP
			&& ALU_REQ.op != OP_BRANCH && ALU_REQ.op != OP_NONE)
			work_accumulator <= alu.result; // RULE_01
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			save_acc   <= ACC_RESET;
			save_flags <= 8'h00;
		end
		else if (SAVE)
		begin
			save_acc   <= work_accumulator; // RULE_04
			save_flags <= status_now;
		end
	end

	// cause is a strap level: caught by the first clock after reset release
	always_ff @(posedge CLK)
	begin
		if (RESET)
			caught <= 1'b0;
		else
			caught <= 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			reset_cause <= CAUSE_PIN;
		else if (!caught)
			reset_cause <= RESET_CAUSE; // RULE_05
		else if (RESTORE)
			reset_cause <= save_flags[BIT_CAUSE_HI:BIT_CAUSE_LO];
		else if (flags_hit && MEM_REQ.write)
			reset_cause <= next_flags[BIT_CAUSE_HI:BIT_CAUSE_LO];
	end

	// comparator levels are asynchronous: three stages, act when last two agree
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sync_high <= 3'h0;
			sync_mid  <= 3'h0;
			supply_low_high_thresh_flag <= 1'b0;
			supply_low_mid_thresh_flag  <= 1'b0;
		end
		else
		begin
			sync_high <= {sync_high[1:0], LV_HIGH_IN};
			sync_mid  <= {sync_mid[1:0], LV_MID_IN};
			// option off forces zero even while the comparator is bouncing
			if (!OPT_HIGH)
				supply_low_high_thresh_flag <= 1'b0; // RULE_06
			else if (sync_high[2] == sync_high[1])
				supply_low_high_thresh_flag <= sync_high[2]; // RULE_06
			if (!OPT_MID)
				supply_low_mid_thresh_flag <= 1'b0; // RULE_07
			else if (sync_mid[2] == sync_mid[1])
				supply_low_mid_thresh_flag <= sync_mid[2]; // RULE_07
		end
	end

	// interrupt entry has no path here: accumulator and flags just hold // RULE_03
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			carry           <= 1'b0;
			nibble_half_bit <= 1'b0;
			zero            <= 1'b0;
		end
		else if (RESTORE)
		begin
			carry           <= save_flags[BIT_CARRY]; // RULE_04
			nibble_half_bit <= save_flags[BIT_HALF];
			zero            <= save_flags[BIT_ZERO];
		end
		else if (ALU_REQ.valid && ALU_REQ.op != OP_NONE)
		begin
			if (alu.upd_carry)
				carry <= alu.carry; // RULE_08
			if (alu.upd_half)
				nibble_half_bit <= alu.half; // RULE_09
			zero <= alu.zero; // RULE_10
		end
		else if (flags_hit && MEM_REQ.write)
		begin
			carry           <= next_flags[BIT_CARRY]; // RULE_13
			nibble_half_bit <= next_flags[BIT_HALF];
			zero            <= next_flags[BIT_ZERO];
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			ACC          <= ACC_RESET;
			FLAGS        <= 8'h00;
			MEM_RDATA    <= 8'h00;
			ALU_RESULT   <= 8'h00;
			RESULT_VALID <= 1'b0;
		end
		else
		begin
			ACC   <= work_accumulator;
			FLAGS        <= status_now; // RULE_13
			MEM_RDATA    <= flags_hit ? status_now : 8'h00;
			ALU_RESULT   <= alu.result;
			RESULT_VALID <= ALU_REQ.valid && ALU_REQ.to_mem;
		end
	end

	property p_bit3_zero;
		@(posedge CLK) disable iff (RESET) FLAGS[3] == 1'b0;
	endproperty
	a_bit3_zero: assert property (p_bit3_zero) else $error("bit 3 not zero"); // RULE_13

	property p_int_hold;
		@(posedge CLK) disable iff (RESET)
		(INT_ENTRY && !ALU_REQ.valid && !RESTORE && !(flags_hit && MEM_REQ.write))
		|=> work_accumulator == $past(work_accumulator) && carry == $past(carry);
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("interrupt entry changed state"); // RULE_03

	sequence s_save;
		SAVE && !RESTORE && !ALU_REQ.valid && !MEM_REQ.valid;
	endsequence
	sequence s_restore;
		RESTORE && !SAVE;
	endsequence
	property p_save_restore;
		@(posedge CLK) disable iff (RESET)
		s_save ##1 s_restore |=> work_accumulator == $past(work_accumulator, 2)
			&& zero == $past(zero, 2);
	endproperty
	a_save_restore: assert property (p_save_restore) else $error("restore mismatch"); // RULE_04

	property p_zero;
		@(posedge CLK) disable iff (RESET)
		(ALU_REQ.valid && ALU_REQ.op != OP_NONE && !RESTORE) |=> zero == (ALU_RESULT == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_10

	property p_carry_add;
		@(posedge CLK) disable iff (RESET)
		(ALU_REQ.valid && ALU_REQ.op == OP_ADD && !RESTORE)
		|=> carry == ({1'b0, $past(work_accumulator)} + {1'b0, $past(ALU_REQ.operand)} > 9'h0FF);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry wrong"); // RULE_08

	property p_half_add;
		@(posedge CLK) disable iff (RESET)
		(ALU_REQ.valid && ALU_REQ.op == OP_ADD && !RESTORE)
		|=> nibble_half_bit == ({1'b0, $past(work_accumulator[3:0])}
			+ {1'b0, $past(ALU_REQ.operand[3:0])} > 5'h0F);
	endproperty
	a_half_add: assert property (p_half_add) else $error("half carry wrong"); // RULE_09

	property p_lv_high;
		@(posedge CLK) disable iff (RESET)
		!OPT_HIGH [*3] |=> !supply_low_high_thresh_flag;
	endproperty
	a_lv_high: assert property (p_lv_high) else $error("high flag without option"); // RULE_06

	property p_lv_mid;
		@(posedge CLK) disable iff (RESET)
		(OPT_MID && LV_MID_IN) [*4] |=> supply_low_mid_thresh_flag;
	endproperty
	a_lv_mid: assert property (p_lv_mid) else $error("mid flag missed"); // RULE_07

	property p_cause;
		@(posedge CLK) $fell(RESET) |=> reset_cause == $past(RESET_CAUSE);
	endproperty
	a_cause: assert property (p_cause) else $error("reset cause not caught"); // RULE_05
endmodule
